/* File: rtl/ith_regs.svh */
`ifndef ITH_REGS_SVH
`define ITH_REGS_SVH

// ****************************************************************
// Register offsets and bus target address
// ****************************************************************
`define ITH_ADR_DEVSTAT   8'h00
`define ITH_ADR_PRESS     8'h01
`define ITH_ADR_SMP0LO    8'h02
`define ITH_ADR_SMPLAST   8'h09
`define ITH_ADR_MODECTL   8'h0A
`define ITH_ADR_CHANACT   8'h0C
`define ITH_ADR_SENS0     8'h0E
`define ITH_ADR_SENS1     8'h10
`define ITH_ADR_ALERTPOL  8'h11
`define ITH_ADR_SENS2     8'h12
`define ITH_ADR_SENS3     8'h14
`define ITH_ADR_PRESSPOL  8'h1C
`define ITH_ADR_RAWBASE   8'h30
`define ITH_ADR_RAWLAST   8'h3B
`define ITH_I2C_ADDR      7'h2A

// ****************************************************************
// Field positions
// ****************************************************************
`define ITH_SETUP_HOLD_BIT 0
`define ITH_ALG_SEL_BIT    7
`define ITH_ALERT_POL_BIT  0
`define ITH_FRESH_BIT      7
`define ITH_PERMIT_BIT     0
`define ITH_ERR_BIT        1
`define ITH_HOLD_ECHO_BIT  2

// ****************************************************************
// Reset values
// ****************************************************************
`define ITH_RST_MODECTL   8'h00
`define ITH_RST_CHANACT   8'h01
`define ITH_RST_ALERTPOL  8'h80
`define ITH_RST_PRESSPOL  8'h0F
`define ITH_RST_SENS      8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define ITH_CLK_KHZ       40000
`define ITH_SCAN_MS       100
`define ITH_SCAN_CYC      (`ITH_SCAN_MS * `ITH_CLK_KHZ)

`endif

/* File: rtl/ith_pkg.sv */
package ith_pkg;

  // One finished conversion handed over by the converter front end.
  typedef struct packed {
    logic [1:0]  ch;
    logic [23:0] raw;
    logic [11:0] proc;
    logic        press;
    logic        err;
  } ith_sample_t;

  // Control handed to the converter front end.
  typedef struct packed {
    logic            start;
    logic [1:0]      ch;
    logic [3:0][5:0] gain;
    logic            btnMode;
    logic            lowPower;
  } ith_fe_ctrl_t;

  typedef enum logic [3:0] {
    ITH_IDLE  = 4'b0000,
    ITH_ADDR  = 4'b0001,
    ITH_AACK  = 4'b0010,
    ITH_PTR   = 4'b0011,
    ITH_PACK  = 4'b0100,
    ITH_WDATA = 4'b0101,
    ITH_WACK  = 4'b0110,
    ITH_RDATA = 4'b0111,
    ITH_RACK  = 4'b1000
  } ith_i2c_st_t;

  // Whole state of the host interface block.
  typedef struct packed {
    logic                   sclM, sclS, sclP, sdaM, sdaS, sdaP, pwrM, pwrS;
    ith_i2c_st_t            st;
    logic [3:0]             bitCnt;
    logic [7:0]             shift;
    logic                   rw;
    logic [7:0]             ptr;
    logic                   sdaOeN;
    logic [7:0]             modeCtl, chanAct, alertPol, pressPol;
    logic [3:0][7:0]        sens;
    logic                   permit, errFlag, convBusy;
    logic [31:0]            scanTmr;
    logic [3:0]             scanPend;
    ith_sample_t [1:0]      fifo;
    logic                   wrPtr, rdPtr;
    logic [1:0]             cnt;
    logic                   smpReady;
    logic [3:0][23:0]       raw;
    logic [3:0][11:0]       proc;
    logic [3:0]             press;
    logic                   fresh, alert;
    logic [3:0][23:0]       lraw;
    logic [3:0][11:0]       lproc;
    logic [3:0]             lpress;
    logic                   lfresh;
    logic [3:0]             btnPin;
    logic                   alertOeN;
    ith_fe_ctrl_t           fe;
  } ith_state_t;

endpackage

/* File: rtl/ith_host_if.sv */
// Functional notes
// - Algorithm select zero means raw mode.
// - Raw mode bypasses tracking, algorithms, thresholds.
// - Button mode: processed registers and button pins.
// - Channel bits enable; low-power needs enable.
// - Active channels sampled in sequence per scan.
// - Fresh flag marks new readable data.
// - Raw mode raises alert on new data.
// - Raw sample: 24 bits over three bytes.
// - Push-pull button pins, polarity per bit.
// - Open-drain alert on press or error.
// - Status read clears pending alert.
// - Four press flags, one per channel.
// - Processed sample 12-bit, sign sense selectable.
// - Sensitivity step picks one of 64 gains.
// - Tracking always on in button mode.
// - Pointer auto-increments during read/write bursts.
// - Answer only target address 0x2A.
// - Address byte then register pointer byte.
// - Config writes need hold bit and permit.
// - Scan restarts within 1 ms after hold.
// - Clock line never driven; no stretching.
// - Low power pin keeps only low-power channels.
// - Hold bit stops conversion.
`timescale 1ns/100ps
`default_nettype none
`include "ith_regs.svh"
module ith_host_if #(
  parameter int unsigned SCAN_PERIOD_CYCLES = `ITH_SCAN_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  sclIn,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOeN,
  output logic                       alertOut,
  output logic                       alertOeN,
  output logic [3:0]                 btnPin,
  input  wire logic                  powerLevelPin,
  input  wire logic                  smpValid,
  input  wire ith_pkg::ith_sample_t  smpData,
  output logic                       smpReady,
  output ith_pkg::ith_fe_ctrl_t      feCtrl
);

  ith_pkg::ith_state_t  s;
  ith_pkg::ith_state_t  n;
  ith_pkg::ith_sample_t head;
  logic                 sclRise, sclFall, startCond, stopCond;
  logic                 hostReading, accept, drainEn, loadRd, lockEv;
  logic                 cfgHold, btnMode;
  logic [3:0]           activeMask;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Sensitivity register decode, shared by reads and writes: {hit, index}.
  function automatic logic [2:0] sensSel(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    if (a == `ITH_ADR_SENS0) begin
      r = 3'h4;
    end else if (a == `ITH_ADR_SENS1) begin
      r = 3'h5;
    end else if (a == `ITH_ADR_SENS2) begin
      r = 3'h6;
    end else if (a == `ITH_ADR_SENS3) begin
      r = 3'h7;
    end
    return r;
  endfunction

  // Lowest pending channel, so a round walks channels upward.
  function automatic logic [1:0] lowIdx(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h3;
    if (m[0]) begin
      r = 2'h0;
    end else if (m[1]) begin
      r = 2'h1;
    end else if (m[2]) begin
      r = 2'h2;
    end
    return r;
  endfunction

  // Read decode; data registers answer from the locked copies only.
  function automatic logic [7:0] rdByte(input ith_pkg::ith_state_t st, input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] off;
    logic [7:0] pofs;
    logic [7:0] sub;
    logic [1:0] ch;
    logic [2:0] sel;
    r    = 8'h00;
    sel  = sensSel(a);
    pofs = a - `ITH_ADR_SMP0LO;
    off  = a - `ITH_ADR_RAWBASE;
    ch   = (off >= 8'h09) ? 2'h3 : (off >= 8'h06) ? 2'h2 : (off >= 8'h03) ? 2'h1 : 2'h0;
    sub  = off - {5'h00, ch, 1'b0} - {6'h00, ch};
    if (a == `ITH_ADR_DEVSTAT) begin
      r[`ITH_PERMIT_BIT]    = st.permit;
      r[`ITH_ERR_BIT]       = st.errFlag;
      r[`ITH_HOLD_ECHO_BIT] = st.modeCtl[`ITH_SETUP_HOLD_BIT];
    end else if (a == `ITH_ADR_PRESS) begin
      r[`ITH_FRESH_BIT] = st.lfresh;
      r[3:0]            = st.lpress;
    end else if (a >= `ITH_ADR_SMP0LO && a <= `ITH_ADR_SMPLAST) begin
      r = pofs[0] ? {4'h0, st.lproc[pofs[2:1]][11:8]} : st.lproc[pofs[2:1]][7:0];
    end else if (a == `ITH_ADR_MODECTL) begin
      r = st.modeCtl;
    end else if (a == `ITH_ADR_CHANACT) begin
      r = st.chanAct;
    end else if (a == `ITH_ADR_ALERTPOL) begin
      r = st.alertPol;
    end else if (a == `ITH_ADR_PRESSPOL) begin
      r = st.pressPol;
    end else if (sel[2]) begin
      r = st.sens[sel[1:0]];
    end else if (a >= `ITH_ADR_RAWBASE && a <= `ITH_ADR_RAWLAST) begin
      // Three bytes per channel, most significant first.
      case (sub)
        8'h00:   r = st.lraw[ch][23:16];
        8'h01:   r = st.lraw[ch][15:8];
        default: r = st.lraw[ch][7:0];
      endcase
    end
    return r;
  endfunction

  // ****************************************************************
  // Decoded events
  // ****************************************************************

  // Edges come from the second and third synchroniser stages only.
  assign sclRise     = s.sclS & ~s.sclP;
  assign sclFall     = ~s.sclS & s.sclP;
  assign startCond   = s.sclS & s.sclP & s.sdaP & ~s.sdaS;
  assign stopCond    = s.sclS & s.sclP & ~s.sdaP & s.sdaS;
  assign cfgHold     = s.modeCtl[`ITH_SETUP_HOLD_BIT];
  assign btnMode     = s.alertPol[`ITH_ALG_SEL_BIT];
  assign activeMask  = s.pwrS ? s.chanAct[3:0] : (s.chanAct[3:0] & s.chanAct[7:4]);
  assign hostReading = (s.st == ith_pkg::ITH_RDATA) || (s.st == ith_pkg::ITH_RACK);
  assign head        = s.fifo[s.rdPtr];
  // The buffer is drained only while no read byte is being shifted, so a slow host stalls the converter.
  assign accept      = smpValid & s.smpReady;
  assign drainEn     = (s.cnt != 2'h0) & ~hostReading;
  assign loadRd      = sclFall && ((s.st == ith_pkg::ITH_AACK && s.rw) || s.st == ith_pkg::ITH_RACK);
  assign lockEv      = loadRd && (s.ptr == `ITH_ADR_DEVSTAT);

  // ****************************************************************
  // Next state
  // ****************************************************************

  // All behaviour of the block is computed here from the registered state and the inputs.
  always_comb begin
    logic [7:0] rd;
    logic [2:0] wsel;
    logic [1:0] pick;
    rd   = rdByte(s, s.ptr);
    wsel = sensSel(s.ptr);
    pick = lowIdx(s.scanPend);
    n    = s;

    // Two-flop synchronisers; a third stage feeds the edge detectors.
    n.sclM = sclIn;
    n.sclS = s.sclM;
    n.sclP = s.sclS;
    n.sdaM = sdaIn;
    n.sdaS = s.sdaM;
    n.sdaP = s.sdaS;
    n.pwrM = powerLevelPin;
    n.pwrS = s.pwrM;

    // Target state machine; it only ever drives the data line, never the clock.
    if (startCond) begin
      n.st     = ith_pkg::ITH_ADDR;
      n.bitCnt = 4'h0;
      n.sdaOeN = 1'b1;
    end else if (stopCond) begin
      n.st     = ith_pkg::ITH_IDLE;
      n.sdaOeN = 1'b1;
    end else if (sclRise) begin
      case (s.st)
        ith_pkg::ITH_ADDR, ith_pkg::ITH_PTR, ith_pkg::ITH_WDATA: begin
          n.shift  = {s.shift[6:0], s.sdaS};
          n.bitCnt = s.bitCnt + 4'h1;
        end
        ith_pkg::ITH_RACK: begin
          // A not-acknowledge ends the burst; the line is already released.
          if (s.sdaS) begin
            n.st = ith_pkg::ITH_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      case (s.st)
        ith_pkg::ITH_ADDR: begin
          if (s.bitCnt == 4'h8) begin
            if (s.shift[7:1] == `ITH_I2C_ADDR) begin
              n.st     = ith_pkg::ITH_AACK;
              n.rw     = s.shift[0];
              n.sdaOeN = 1'b0;
            end else begin
              n.st = ith_pkg::ITH_IDLE;
            end
          end
        end
        ith_pkg::ITH_AACK: begin
          if (!s.rw) begin
            n.st     = ith_pkg::ITH_PTR;
            n.bitCnt = 4'h0;
            n.sdaOeN = 1'b1;
          end
        end
        ith_pkg::ITH_PTR: begin
          if (s.bitCnt == 4'h8) begin
            n.ptr    = s.shift;
            n.st     = ith_pkg::ITH_PACK;
            n.sdaOeN = 1'b0;
          end
        end
        ith_pkg::ITH_PACK, ith_pkg::ITH_WACK: begin
          n.st     = ith_pkg::ITH_WDATA;
          n.bitCnt = 4'h0;
          n.sdaOeN = 1'b1;
        end
        ith_pkg::ITH_WDATA: begin
          if (s.bitCnt == 4'h8) begin
            // The hold control is always writable; the rest only once the permit is up.
            if (s.ptr == `ITH_ADR_MODECTL) begin
              n.modeCtl = s.shift;
            end else if (s.permit) begin
              if (s.ptr == `ITH_ADR_CHANACT) begin
                n.chanAct = s.shift;
              end else if (s.ptr == `ITH_ADR_ALERTPOL) begin
                n.alertPol = s.shift;
              end else if (s.ptr == `ITH_ADR_PRESSPOL) begin
                n.pressPol = s.shift;
              end else if (wsel[2]) begin
                n.sens[wsel[1:0]] = s.shift;
              end
            end
            n.ptr    = s.ptr + 8'h01;
            n.st     = ith_pkg::ITH_WACK;
            n.sdaOeN = 1'b0;
          end
        end
        ith_pkg::ITH_RDATA: begin
          if (s.bitCnt == 4'h7) begin
            n.st     = ith_pkg::ITH_RACK;
            n.sdaOeN = 1'b1;
          end else begin
            n.bitCnt = s.bitCnt + 4'h1;
            n.shift  = {s.shift[6:0], 1'b0};
            n.sdaOeN = s.shift[6];
          end
        end
        default: begin
        end
      endcase
      // Loading a read byte; releasing the line sends a one, pulling it sends a zero.
      if (loadRd) begin
        n.st     = ith_pkg::ITH_RDATA;
        n.bitCnt = 4'h0;
        n.shift  = rd;
        n.sdaOeN = rd[7];
        n.ptr    = s.ptr + 8'h01;
      end
    end

    // A status read freezes the data copies and clears the pending flags.
    if (lockEv) begin
      n.lraw    = s.raw;
      n.lproc   = s.proc;
      n.lpress  = s.press;
      n.lfresh  = s.fresh;
      n.fresh   = 1'b0;
      n.alert   = 1'b0;
      n.errFlag = 1'b0;
    end

    // Permit rises only with the hold set and nothing in flight or buffered.
    n.permit = cfgHold & ~s.convBusy & (s.cnt == 2'h0);

    // Scan scheduler: each period queues every active channel, issued one at a time.
    n.fe.start = 1'b0;
    if (cfgHold) begin
      n.scanPend = 4'h0;
      n.scanTmr  = 32'h0000_0000;
    end else begin
      if (s.scanTmr == 32'h0000_0000) begin
        n.scanTmr  = 32'(SCAN_PERIOD_CYCLES - 1);
        n.scanPend = s.scanPend | activeMask;
      end else begin
        n.scanTmr = s.scanTmr - 32'h0000_0001;
      end
      if (!s.convBusy && s.scanPend != 4'h0) begin
        n.fe.start       = 1'b1;
        n.fe.ch          = pick;
        n.convBusy       = 1'b1;
        n.scanPend[pick] = 1'b0;
      end
    end
    if (accept && s.convBusy) begin
      n.convBusy = 1'b0;
    end

    // Two-entry buffer between converter and register bank.
    if (accept) begin
      n.fifo[s.wrPtr] = smpData;
      n.wrPtr         = ~s.wrPtr;
    end
    if (drainEn) begin
      n.rdPtr = ~s.rdPtr;
    end
    case ({accept, drainEn})
      2'b10:   n.cnt = s.cnt + 2'h1;
      2'b01:   n.cnt = s.cnt - 2'h1;
      default: n.cnt = s.cnt;
    endcase
    n.smpReady = (n.cnt != 2'h2);

    // Live registers; flag sets come after the lock so a coinciding event wins.
    if (drainEn) begin
      n.raw[head.ch] = head.raw;
      n.fresh        = 1'b1;
      if (btnMode) begin
        n.proc[head.ch]  = s.pressPol[{1'b1, head.ch}] ? 12'(12'h000 - head.proc) : head.proc;
        n.press[head.ch] = head.press;
        if (head.press || head.err) begin
          n.alert = 1'b1;
        end
        if (head.err) begin
          n.errFlag = 1'b1;
        end
      end else begin
        n.alert = 1'b1;
      end
    end
    // Raw mode carries no thresholded press state.
    if (!btnMode) begin
      n.press = 4'h0;
    end

    // Pins: push-pull press outputs, open-drain alert driven low for a low level.
    n.btnPin   = ~(s.press ^ s.pressPol[3:0]);
    n.alertOeN = s.alertPol[`ITH_ALERT_POL_BIT] ? s.alert : ~s.alert;

    // Front end control; tracking follows the mode and cannot be turned off alone.
    for (int i = 0; i < 4; i++) begin
      n.fe.gain[i] = s.sens[i][5:0];
    end
    n.fe.btnMode  = btnMode;
    n.fe.lowPower = ~s.pwrS;

    if (sys_rst) begin
      n          = '0;
      n.sclM     = 1'b1;
      n.sclS     = 1'b1;
      n.sclP     = 1'b1;
      n.sdaM     = 1'b1;
      n.sdaS     = 1'b1;
      n.sdaP     = 1'b1;
      n.pwrM     = 1'b1;
      n.pwrS     = 1'b1;
      n.sdaOeN   = 1'b1;
      n.modeCtl  = `ITH_RST_MODECTL;
      n.chanAct  = `ITH_RST_CHANACT;
      n.alertPol = `ITH_RST_ALERTPOL;
      n.pressPol = `ITH_RST_PRESSPOL;
      n.sens     = {4{`ITH_RST_SENS}};
      n.smpReady = 1'b1;
      n.btnPin   = 4'h0;
      n.alertOeN = 1'b1;
    end
  end

  // Single state register.
  always_ff @(posedge clk) begin
    s <= n;
  end

  // Outputs come straight from the state register, except sdaOut and alertOut, which are tied low.
  assign sdaOut   = 1'b0;
  assign sdaOeN   = s.sdaOeN;
  assign alertOut = 1'b0;
  assign alertOeN = s.alertOeN;
  assign btnPin   = s.btnPin;
  assign smpReady = s.smpReady;
  assign feCtrl   = s.fe;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence holdReleased;
    $fell(cfgHold) && !s.convBusy && (activeMask != 4'h0);
  endsequence

  sequence scanIssued;
    ##[1:4] s.fe.start;
  endsequence

  AST_RESTART: assert property (holdReleased |-> scanIssued)
    else $error("No scan started after hold release.");
  AST_HOLD_STOPS: assert property ($past(cfgHold) && cfgHold |-> !s.fe.start)
    else $error("Conversion started while held.");
  AST_PERMIT: assert property (s.permit |-> $past(cfgHold && !s.convBusy && s.cnt == 2'h0))
    else $error("Write permit raised before conversion halted.");
  AST_RAW_ALERT: assert property (drainEn && !btnMode |=> s.alert)
    else $error("Raw data did not raise alert.");
  AST_STATUS_CLR: assert property (lockEv && !drainEn |=> !s.alert && !s.fresh)
    else $error("Status read left alert pending.");
  AST_LOCK_HOLD: assert property (!lockEv |=> $stable(s.lraw) && $stable(s.lproc) && $stable(s.lpress))
    else $error("Locked data changed without status read.");
  AST_BTN_PIN: assert property (##1 s.btnPin == $past(~(s.press ^ s.pressPol[3:0])))
    else $error("Button pin level wrong.");
  AST_RAW_NOPRESS: assert property ($past(!btnMode) |-> s.press == 4'h0)
    else $error("Press state present in raw mode.");
  AST_ADDR_NAK: assert property (sclFall && s.st == ith_pkg::ITH_ADDR && s.bitCnt == 4'h8 &&
                                 s.shift[7:1] != `ITH_I2C_ADDR |=> s.sdaOeN && s.st == ith_pkg::ITH_IDLE)
    else $error("Foreign address acknowledged.");
  AST_BURST_INC: assert property (loadRd && !startCond && !stopCond |=> s.ptr == $past(s.ptr) + 8'h01)
    else $error("Pointer did not advance.");

endmodule
`default_nettype wire

/* File: test/ith_conv_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ********
// Converter front end
// ********
module ith_conv_model (
  input  wire logic                  clk,
  input  wire ith_pkg::ith_fe_ctrl_t feCtrl,
  input  wire logic                  smpReady,
  output logic                       smpValid,
  output ith_pkg::ith_sample_t       smpData
);
  logic [7:0] seqNo;
  logic [1:0] chNo;
  logic       slow;
  // One sample per start, alternately prompt and slow. The top raw byte counts
  // samples, so a stale or torn locked copy can be told from a fresh one.
  initial begin
    smpValid = 1'b0;
    smpData  = '0;
    seqNo    = 8'h00;
    slow     = 1'b0;
    forever begin
      @(negedge clk);
      if (feCtrl.start === 1'b1) begin
        chNo = feCtrl.ch;
        repeat (slow ? 6 : 1) @(negedge clk);
        smpData       = '0;
        smpData.ch    = chNo;
        smpData.raw   = {seqNo, 16'h3450};
        smpData.proc  = 12'h0A5;
        smpData.press = feCtrl.btnMode && (chNo == 2'h0);
        smpValid      = 1'b1;
        while (smpReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        smpValid = 1'b0;
        smpData  = ~smpData;  // A released bus must not look like the last word.
        seqNo    = seqNo + 8'h01;
        slow     = ~slow;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/ith_host_if_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ith_regs.svh"
module ith_host_if_tb;
  logic                  clk, sysRst, sclH, sdaH, pwrPin, ack, sdaOut, sdaOeN, alertOut, alertOeN;
  logic                  smpReady, smpValid;
  logic [3:0]            btnPin;
  logic [7:0]            rdBuf [8];
  logic [7:0]            b0;
  int                    numErrors = 0, totalChecks = 0, cyc = 0;
  ith_pkg::ith_sample_t  smpData;
  ith_pkg::ith_fe_ctrl_t feCtrl;
  // Open-drain data line: either side can only pull it low.
  wire logic             sda = sdaH & (sdaOeN | sdaOut);

  ith_host_if #(.SCAN_PERIOD_CYCLES(5000)) dut (.clk(clk), .sys_rst(sysRst), .sclIn(sclH), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .alertOut(alertOut), .alertOeN(alertOeN), .btnPin(btnPin),
    .powerLevelPin(pwrPin), .smpValid(smpValid), .smpData(smpData), .smpReady(smpReady), .feCtrl(feCtrl));
  ith_conv_model conv (.clk(clk), .feCtrl(feCtrl), .smpReady(smpReady), .smpValid(smpValid), .smpData(smpData));

  // 40 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // A hang is cut short well after the expected run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      numErrors = numErrors + 1;
      wrapUp();
    end
  end

  // ********
  // Bus tasks
  // ********
  // Half SCL periods of 600 ns keep the bus within the device's sampling.
  task automatic hp; repeat (24) @(negedge clk); endtask
  // Data moves mid-low so it never changes near an SCL edge.
  task automatic bitx(input logic b, output logic r);
    repeat (12) @(negedge clk);
    sdaH = b;
    repeat (12) @(negedge clk);
    sclH = 1'b1;
    hp();
    r    = sda;
    sclH = 1'b0;
  endtask
  task automatic i2cStart; hp(); sdaH = 1'b1; hp(); sclH = 1'b1; hp(); sdaH = 1'b0; hp(); sclH = 1'b0; endtask
  task automatic i2cStop; hp(); sdaH = 1'b0; hp(); sclH = 1'b1; hp(); sdaH = 1'b1; hp(); endtask
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i2cStart(); wbyte({`ITH_I2C_ADDR, 1'b0}); wbyte(a); wbyte(d); i2cStop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    i2cStart(); wbyte({`ITH_I2C_ADDR, 1'b0}); wbyte(a); i2cStart(); wbyte({`ITH_I2C_ADDR, 1'b1});
    for (int i = 0; i < n; i++) rbyte(i == n - 1, rdBuf[i]);
    i2cStop();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks = totalChecks + 1;
    if (got !== exp) begin
      numErrors = numErrors + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Enter configuration mode and poll until writes are permitted.
  task automatic cfgOn;
    wr(`ITH_ADR_MODECTL, 8'h01);
    rdBuf[0] = 8'h00;
    for (int i = 0; i < 8 && rdBuf[0][0] !== 1'b1; i++) rd(`ITH_ADR_DEVSTAT, 1);
    chk(rdBuf[0] & 8'h01, 8'h01);
  endtask
  task automatic waitAlert; for (int i = 0; i < 6000 && alertOeN !== 1'b0; i++) @(negedge clk); endtask
  task automatic wrapUp;
    $display("Checks %0d, mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    sysRst = 1'b1; sclH = 1'b1; sdaH = 1'b1; pwrPin = 1'b1;
    repeat (2) @(negedge clk);
    sysRst = 1'b0;
    repeat (4) @(negedge clk);
    rd(`ITH_ADR_MODECTL, 3);
    chk(rdBuf[0], `ITH_RST_MODECTL);
    chk(rdBuf[1], 8'h00);
    chk(rdBuf[2], `ITH_RST_CHANACT);
    rd(`ITH_ADR_ALERTPOL, 1); chk(rdBuf[0], `ITH_RST_ALERTPOL);
    rd(`ITH_ADR_PRESSPOL, 1); chk(rdBuf[0], `ITH_RST_PRESSPOL);
    i2cStart(); wbyte({7'h2B, 1'b0}); i2cStop(); chk({7'h00, ack}, 8'h00);
    $display("Test reset and addressing done.");
    wr(`ITH_ADR_CHANACT, 8'h03); rd(`ITH_ADR_CHANACT, 1); chk(rdBuf[0], `ITH_RST_CHANACT);
    cfgOn(); wr(`ITH_ADR_CHANACT, 8'h03); wr(`ITH_ADR_ALERTPOL, 8'h00);
    rd(`ITH_ADR_CHANACT, 1); chk(rdBuf[0], 8'h03);
    wr(`ITH_ADR_SENS1, 8'hEC); rd(`ITH_ADR_SENS1, 1); chk(rdBuf[0], 8'hEC);
    chk({2'h0, feCtrl.gain[1]}, 8'h2C);
    chk({7'h00, feCtrl.btnMode}, 8'h00);
    wr(`ITH_ADR_MODECTL, 8'h00);
    $display("Test configuration handshake done.");
    waitAlert(); chk({7'h00, alertOeN}, 8'h00);
    rd(`ITH_ADR_DEVSTAT, 1); chk({7'h00, alertOeN}, 8'h01);
    rd(`ITH_ADR_PRESS, 1); chk(rdBuf[0], 8'h80);
    rd(`ITH_ADR_RAWBASE, 6); b0 = rdBuf[0];
    for (int i = 1; i < 6; i++) chk(rdBuf[i], (i % 3 == 0) ? b0 + 8'h01 : (i % 3 == 1) ? 8'h34 : 8'h50);
    waitAlert(); rd(`ITH_ADR_RAWBASE, 1); chk(rdBuf[0], b0);
    $display("Test raw mode done.");
    cfgOn(); wr(`ITH_ADR_ALERTPOL, 8'h80); wr(`ITH_ADR_MODECTL, 8'h00);
    for (int i = 0; i < 6000 && btnPin[0] !== 1'b1; i++) @(negedge clk);
    chk({4'h0, btnPin}, 8'h01);
    chk({7'h00, alertOeN}, 8'h00);
    rd(`ITH_ADR_DEVSTAT, 1); rd(`ITH_ADR_PRESS, 3);
    chk(rdBuf[0], 8'h81);
    chk(rdBuf[1], 8'hA5);
    chk(rdBuf[2], 8'h00);
    $display("Test button mode done.");
    cfgOn(); wr(`ITH_ADR_PRESSPOL, 8'h1E); wr(`ITH_ADR_MODECTL, 8'h00);
    rd(`ITH_ADR_DEVSTAT, 1); waitAlert(); rd(`ITH_ADR_DEVSTAT, 1); rd(`ITH_ADR_SMP0LO, 2);
    chk(rdBuf[0], 8'h5B);
    chk(rdBuf[1], 8'h0F);
    chk({4'h0, btnPin}, 8'h00);
    pwrPin = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h00, feCtrl.lowPower}, 8'h01);
    $display("Test polarity and power level done.");
    wrapUp();
  end
endmodule
`default_nettype wire
